// [rtl/phsl_strap_latch.sv]
// Strap latch: samples configuration straps during reset and loads the
// control and advertisement registers; pins turn into outputs afterwards.
// Assumes the management port is driven from logic on clk_in.
`timescale 1ns/100ps
module phsl_strap_latch
  import phsl_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire phsl_strap_type strap_pin_in,
  input wire phsl_strap_type pin_func_in,
  input wire phsl_mgmt_type mgmt_in,
  output phsl_strap_type strap_pin_out,
  output phsl_strap_type strap_pin_oe_out,
  output logic strap_pull_en_out,
  output phsl_strap_type strap_latched_out,
  output logic [15:0] ctrl_reg_out,
  output logic [15:0] adv_reg_out,
  output logic [15:0] rd_data_out,
  output logic rd_valid_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  phsl_strap_type pin_level;
  phsl_state_type state_q;
  phsl_state_type state_d;
  phsl_strap_type latched_q;
  phsl_strap_type latched_d;
  phsl_strap_type oe_q;
  phsl_strap_type oe_d;
  phsl_strap_type pin_out_q;
  phsl_strap_type pin_out_d;
  logic pull_q;
  logic pull_d;
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  logic [15:0] adv_q;
  logic [15:0] adv_d;
  logic [15:0] rd_data_q;
  logic [15:0] rd_data_d;
  logic rd_valid_q;
  logic rd_valid_d;

  // Control word built from captured straps
  function automatic logic [15:0] ctrl_from_straps(input phsl_strap_type s);
    logic [15:0] v;
    v = PHSL_CTRL_RESET;
    v[PHSL_CTRL_ISO_BIT] = s.isolate;
    v[PHSL_CTRL_SPEED_BIT] = s.speed;
    v[PHSL_CTRL_DUPLEX_BIT] = ~s.duplex;
    v[PHSL_CTRL_ANEG_BIT] = s.autoneg_enable_strap;
    return v;
  endfunction

  // Advertisement word built from the rate strap
  function automatic logic [15:0] adv_from_straps(input phsl_strap_type s);
    logic [15:0] v;
    v = PHSL_ADV_RESET;
    v[PHSL_ADV_TECH_MSB:PHSL_ADV_TECH_LSB] = s.speed ? PHSL_ADV_TECH_100 : PHSL_ADV_TECH_10;
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  phsl_sync3 #(
    .WIDTH($bits(phsl_strap_type))
  ) u_sync (
    .clk_in(clk_in),
    .pin_in(strap_pin_in),
    .level_out(pin_level)
  );

  // ----------------------------------------------------------------
  // Phase control and pin direction
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    oe_d = '0;
    pull_d = 1'b1;
    pin_out_d = pin_func_in;
    case (state_q)
      PHSL_ST_SAMPLE:
      begin
        if (!reset_in)
        begin
          state_d = PHSL_ST_RUN;
          oe_d = '1;
          pull_d = 1'b0;
        end
      end
      PHSL_ST_RUN:
      begin
        oe_d = '1;
        pull_d = 1'b0;
      end
      default:
      begin
        state_d = PHSL_ST_SAMPLE;
      end
    endcase
    if (reset_in)
    begin
      state_d = PHSL_ST_SAMPLE;
      oe_d = '0;
      pull_d = 1'b1;
    end
  end

  // Phase registers
  always_ff @(posedge clk_in)
  begin
    state_q <= state_d;
    oe_q <= oe_d;
    pull_q <= pull_d;
    pin_out_q <= pin_out_d;
  end

  // ----------------------------------------------------------------
  // Strap capture, held outside reset
  // ----------------------------------------------------------------
  always_comb
  begin
    latched_d = latched_q;
    if (reset_in)
    begin
      latched_d = pin_level;
    end
  end

  // Capture register
  always_ff @(posedge clk_in)
  begin
    latched_q <= latched_d;
  end

  // ----------------------------------------------------------------
  // Register bank: strap load, management writes and reads
  // ----------------------------------------------------------------
  always_comb
  begin
    ctrl_d = ctrl_q;
    adv_d = adv_q;
    rd_data_d = rd_data_q;
    rd_valid_d = 1'b0;
    if (reset_in)
    begin
      ctrl_d = PHSL_CTRL_RESET;
      adv_d = PHSL_ADV_RESET;
      rd_data_d = '0;
    end
    else if (state_q == PHSL_ST_SAMPLE)
    begin
      ctrl_d = ctrl_from_straps(latched_q);
      adv_d = adv_from_straps(latched_q);
    end
    else
    begin
      if (mgmt_in.wr)
      begin
        if (mgmt_in.addr == PHSL_CTRL_ADDR)
        begin
          ctrl_d = mgmt_in.wdata;
        end
        else if (mgmt_in.addr == PHSL_ADV_ADDR)
        begin
          adv_d = mgmt_in.wdata;
        end
      end
      if (mgmt_in.rd)
      begin
        rd_valid_d = 1'b1;
        case (mgmt_in.addr)
          PHSL_CTRL_ADDR: rd_data_d = ctrl_q;
          PHSL_ADV_ADDR: rd_data_d = adv_q;
          default: rd_data_d = '0; // Unmapped reads as zero
        endcase
      end
    end
  end

  // Register bank flops
  always_ff @(posedge clk_in)
  begin
    ctrl_q <= ctrl_d;
    adv_q <= adv_d;
    rd_data_q <= rd_data_d;
    rd_valid_q <= rd_valid_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign strap_pin_out = pin_out_q;
  assign strap_pin_oe_out = oe_q;
  assign strap_pull_en_out = pull_q;
  assign strap_latched_out = latched_q;
  assign ctrl_reg_out = ctrl_q;
  assign adv_reg_out = adv_q;
  assign rd_data_out = rd_data_q;
  assign rd_valid_out = rd_valid_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  sequence s_release;
    state_q == PHSL_ST_SAMPLE && !reset_in;
  endsequence

  sequence s_ctrl_write;
    state_q == PHSL_ST_RUN && mgmt_in.wr && mgmt_in.addr == PHSL_CTRL_ADDR;
  endsequence

  a_hold_straps: assert property ($past(state_q) == PHSL_ST_RUN |-> $stable(latched_q))
    else $error("captured straps changed outside reset");
  a_iso_load: assert property (s_release |=> ctrl_q[PHSL_CTRL_ISO_BIT] == latched_q.isolate)
    else $error("isolate strap not loaded");
  a_speed_load: assert property (s_release |=> ctrl_q[PHSL_CTRL_SPEED_BIT] == latched_q.speed)
    else $error("speed strap not loaded");
  a_adv_speed: assert property (s_release |=>
    adv_q[PHSL_ADV_TECH_MSB:PHSL_ADV_TECH_LSB] ==
    (latched_q.speed ? PHSL_ADV_TECH_100 : PHSL_ADV_TECH_10))
    else $error("advertised speed does not follow strap");
  a_duplex_load: assert property (s_release |=> ctrl_q[PHSL_CTRL_DUPLEX_BIT] != latched_q.duplex)
    else $error("duplex strap not loaded");
  a_aneg_load: assert property (s_release |=>
    ctrl_q[PHSL_CTRL_ANEG_BIT] == latched_q.autoneg_enable_strap)
    else $error("autoneg strap not loaded");
  a_pins_input: assert property (state_q == PHSL_ST_SAMPLE |-> oe_q == '0 && pull_q)
    else $error("strap pin driven while sampling");
  a_pins_drive: assert property (s_release |=> oe_q == '1 && !pull_q ##1 oe_q == '1)
    else $error("strap pin not driven after reset");
  a_mgmt_write: assert property (s_ctrl_write |=> ctrl_q == $past(mgmt_in.wdata))
    else $error("management write did not override control");

endmodule

// [rtl/phsl_pkg.sv]
// Package for the strap latch: register map, field positions, reset values.
// Assumes one 50 MHz device clock and a synchronous, active-high chip reset.
package phsl_pkg;

  // ----------------------------------------------------------------
  // Register map (register index on the management port)
  // ----------------------------------------------------------------
  localparam logic [4:0] PHSL_CTRL_ADDR = 5'h00;
  localparam logic [4:0] PHSL_ADV_ADDR = 5'h04;

  // ----------------------------------------------------------------
  // Control register field positions
  // ----------------------------------------------------------------
  localparam int PHSL_CTRL_SPEED_BIT = 13;
  localparam int PHSL_CTRL_ANEG_BIT = 12;
  localparam int PHSL_CTRL_ISO_BIT = 10;
  localparam int PHSL_CTRL_DUPLEX_BIT = 8;

  // ----------------------------------------------------------------
  // Advertisement register fields and values
  // ----------------------------------------------------------------
  localparam int PHSL_ADV_TECH_LSB = 5;
  localparam int PHSL_ADV_TECH_MSB = 8;
  localparam logic [3:0] PHSL_ADV_TECH_100 = 4'hf;
  localparam logic [3:0] PHSL_ADV_TECH_10 = 4'h3;

  // ----------------------------------------------------------------
  // Reset values of the bits not loaded from straps
  // ----------------------------------------------------------------
  localparam logic [15:0] PHSL_CTRL_RESET = 16'h0000;
  localparam logic [15:0] PHSL_ADV_RESET = 16'h0001;

  // ----------------------------------------------------------------
  // Strap default levels (pull direction of the weak internal pulls)
  // ----------------------------------------------------------------
  localparam logic PHSL_ISO_DEFAULT = 1'b0;
  localparam logic PHSL_SPEED_DEFAULT = 1'b1;
  localparam logic PHSL_DUPLEX_DEFAULT = 1'b1;
  localparam logic PHSL_ANEG_DEFAULT = 1'b1;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic isolate;
    logic speed;
    logic duplex;
    logic autoneg_enable_strap;
  } phsl_strap_type;

  localparam phsl_strap_type PHSL_STRAP_DEFAULT = '{
    isolate: PHSL_ISO_DEFAULT,
    speed: PHSL_SPEED_DEFAULT,
    duplex: PHSL_DUPLEX_DEFAULT,
    autoneg_enable_strap: PHSL_ANEG_DEFAULT
  };

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } phsl_mgmt_type;

  typedef enum logic [1:0] {
    PHSL_ST_SAMPLE = 2'b01,
    PHSL_ST_RUN = 2'b10
  } phsl_state_type;

endpackage

// [rtl/phsl_sync3.sv]
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous pins; output moves only when stages 2 and 3 agree.
`timescale 1ns/100ps
module phsl_sync3
  import phsl_pkg::*;
#(
  parameter int WIDTH = 4
)
(
  input wire logic clk_in,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] level_q;
  logic [WIDTH-1:0] level_d;

  // ----------------------------------------------------------------
  // Agreement filter, per bit
  // ----------------------------------------------------------------
  always_comb
  begin
    level_d = level_q;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (s2_q[i] == s3_q[i])
      begin
        level_d[i] = s3_q[i];
      end
    end
  end

  // Sampling chain keeps running through reset
  always_ff @(posedge clk_in)
  begin
    s1_q <= pin_in;
    s2_q <= s1_q;
    s3_q <= s2_q;
    level_q <= level_d;
  end

  assign level_out = level_q;

endmodule

// [test/phsl_board_straps.sv]
// Board side of the strap pins: optional strong resistors and pin resolution.
// Assumes the latch gives an active-high output enable and a weak-pull enable.
`timescale 1ns/100ps
module phsl_board_straps
  import phsl_pkg::*;
(
  input wire logic clk_in,
  input wire phsl_strap_type fit_in,
  input wire phsl_strap_type level_in,
  input wire phsl_strap_type drive_in,
  input wire phsl_strap_type oe_in,
  input wire logic pull_en_in,
  output phsl_strap_type pin_out
);
  logic float_q = 1'b0;
  // Undriven, unpulled pins wander every cycle
  always @(posedge clk_in) float_q <= ~float_q;
  // Chip driver first, then board resistor, then weak pull or float
  always_comb
  begin
    pin_out = (oe_in & drive_in) | (~oe_in & fit_in & level_in)
      | (~oe_in & ~fit_in & (pull_en_in ? PHSL_STRAP_DEFAULT : {4{float_q}}));
  end
endmodule

// [test/tb_phsl_strap_latch.sv]
// Self-checking bench for the strap latch.
// Assumes a 50 MHz clock and board straps modelled by phsl_board_straps.
`timescale 1ns/100ps
module tb_phsl_strap_latch;
  import phsl_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  phsl_strap_type pin_func_in = 4'h0;
  phsl_mgmt_type mgmt_in = '0;
  phsl_strap_type fit = 4'h0;
  phsl_strap_type level = 4'h0;
  phsl_strap_type pins, drv, oe, latched;
  logic pull_en, rd_valid;
  logic [15:0] ctrl, adv, rd_data;
  int err_total = 0;
  int checked = 0;
  // ----------------------------------------------------------------
  // Clock, design and board
  // ----------------------------------------------------------------
  always #10 clk_in = ~clk_in;
  phsl_strap_latch uut (.clk_in(clk_in), .reset_in(reset_in), .strap_pin_in(pins),
    .pin_func_in(pin_func_in), .mgmt_in(mgmt_in), .strap_pin_out(drv),
    .strap_pin_oe_out(oe), .strap_pull_en_out(pull_en), .strap_latched_out(latched),
    .ctrl_reg_out(ctrl), .adv_reg_out(adv), .rd_data_out(rd_data),
    .rd_valid_out(rd_valid));
  phsl_board_straps board (.clk_in(clk_in), .fit_in(fit), .level_in(level),
    .drive_in(drv), .oe_in(oe), .pull_en_in(pull_en), .pin_out(pins));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One management cycle, taken at the next edge
  task automatic mg(input logic w, input logic r, input logic [4:0] a, input logic [15:0] d);
    mgmt_in = '{wr: w, rd: r, addr: a, wdata: d};
    @(posedge clk_in);
    #1;
  endtask
  // Reset with given board resistors, then check the loaded registers
  task automatic do_reset(input phsl_strap_type f, input phsl_strap_type l);
    phsl_strap_type s;
    logic [15:0] c;
    logic [15:0] a;
    @(posedge clk_in);
    #1;
    fit = f;
    level = l;
    reset_in = 1'b1;
    repeat (8) @(posedge clk_in);
    #1;
    cmp({12'h000, oe}, 16'h0000, "oe in reset");
    cmp({15'h0000, pull_en}, 16'h0001, "pull in reset");
    reset_in = 1'b0;
    s = (f & l) | (~f & PHSL_STRAP_DEFAULT);
    c = PHSL_CTRL_RESET;
    c[PHSL_CTRL_SPEED_BIT] = s.speed;
    c[PHSL_CTRL_ANEG_BIT] = s.autoneg_enable_strap;
    c[PHSL_CTRL_ISO_BIT] = s.isolate;
    c[PHSL_CTRL_DUPLEX_BIT] = ~s.duplex;
    a = PHSL_ADV_RESET;
    a[PHSL_ADV_TECH_MSB:PHSL_ADV_TECH_LSB] = s.speed ? PHSL_ADV_TECH_100 : PHSL_ADV_TECH_10;
    @(posedge clk_in);
    #1;
    cmp({12'h000, latched}, {12'h000, s}, "latched");
    cmp({12'h000, oe}, 16'h000f, "oe after");
    cmp({15'h0000, pull_en}, 16'h0000, "pull after");
    cmp(ctrl, c, "ctrl");
    cmp(adv, a, "adv");
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_defaults();
    do_reset(4'h0, 4'h0);
  endtask
  task automatic test_inverted();
    do_reset(4'hf, ~PHSL_STRAP_DEFAULT);
  endtask
  task automatic test_mixed();
    do_reset(4'h9, 4'h8);
  endtask
  // Overrides, unmapped access, late pin changes, recapture
  task automatic test_mgmt();
    mg(1'b1, 1'b0, PHSL_ADV_ADDR, 16'h5a5a);
    cmp(adv, 16'h5a5a, "adv wr");
    mg(1'b1, 1'b0, PHSL_CTRL_ADDR, 16'h0500);
    cmp(ctrl, 16'h0500, "ctrl wr");
    mg(1'b0, 1'b1, PHSL_CTRL_ADDR, 16'h0000);
    cmp({15'h0000, rd_valid}, 16'h0001, "rd valid");
    cmp(rd_data, 16'h0500, "rd ctrl");
    mg(1'b1, 1'b0, 5'h05, 16'hffff);
    cmp(ctrl, 16'h0500, "stray wr ctrl");
    cmp(adv, 16'h5a5a, "stray wr adv");
    mg(1'b0, 1'b1, 5'h1f, 16'h0000);
    cmp({15'h0000, rd_valid}, 16'h0001, "rd unmapped valid");
    cmp(rd_data, 16'h0000, "rd unmapped");
    // Write and read together: read returns the old word
    mg(1'b1, 1'b1, PHSL_ADV_ADDR, 16'h1234);
    cmp(rd_data, 16'h5a5a, "rd old on wr");
    cmp(adv, 16'h1234, "adv wr with rd");
    pin_func_in = 4'ha;
    fit = 4'hf;
    level = 4'h5;
    mg(1'b0, 1'b0, 5'h00, 16'h0000);
    cmp({15'h0000, rd_valid}, 16'h0000, "rd pulse");
    cmp({8'h00, drv, pins}, 16'h00aa, "pins driven");
    cmp({12'h000, latched}, {12'h000, PHSL_STRAP_DEFAULT}, "held");
    cmp(ctrl, 16'h0500, "ctrl held");
    do_reset(4'h0, 4'h0);
  endtask
  // ----------------------------------------------------------------
  // Verdict and sequence
  // ----------------------------------------------------------------
  task automatic results();
    $display("Counts: checked %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    test_defaults();
    test_inverted();
    test_mixed();
    test_defaults();
    test_mgmt();
    results();
  end
  // Watchdog, far beyond the few dozen cycles needed
  initial
  begin
    #20000;
    err_total++;
    results();
  end
endmodule
